/* File: hw/scs_sequencer.sv */
// scale command sequencer: axi4-lite slave, command decoder, cycle fsm
// assumes the weighing core reports cycle events as single-cycle pulses
`timescale 1ns/1ps
module scs_sequencer import scs_pkg::*; (
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic [7:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  output logic [1:0] BRESP_OUT,
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic [7:0] ARADDR_IN,
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  output logic RVALID_OUT,
  input wire logic RREADY_IN,
  input wire scs_proc_t PROC_IN,
  output scs_act_t ACT_OUT,
  output logic PULSE_MODE_OUT,
  output logic EMPTY_OUT,
  output logic INHIBIT_OUT,
  output logic ERR17_OUT,
  output logic IRQ_OUT
);
  // ==========================================
  // axi4-lite write path
  logic aw_ok_reg, w_ok_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  assign wr_fire = aw_ok_reg && w_ok_reg && !BVALID_OUT;
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      aw_ok_reg <= 1'b0;
      w_ok_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      BVALID_OUT <= 1'b0;
      BRESP_OUT <= SCS_RESP_OK;
      AWREADY_OUT <= 1'b0;
      WREADY_OUT <= 1'b0;
    end else begin
      // ready is a flop so every output is registered; low for one cycle after reset
      AWREADY_OUT <= wr_fire || !(aw_ok_reg || (AWVALID_IN && AWREADY_OUT));
      WREADY_OUT <= wr_fire || !(w_ok_reg || (WVALID_IN && WREADY_OUT));
      if (AWVALID_IN && AWREADY_OUT) begin
        aw_ok_reg <= 1'b1;
        awaddr_reg <= AWADDR_IN;
      end
      if (WVALID_IN && WREADY_OUT) begin
        w_ok_reg <= 1'b1;
        wdata_reg <= WDATA_IN;
        wstrb_reg <= WSTRB_IN;
      end
      if (wr_fire) begin
        aw_ok_reg <= 1'b0;
        w_ok_reg <= 1'b0;
        BVALID_OUT <= 1'b1;
        BRESP_OUT <= (awaddr_reg[7:2] <= SCS_ID_OFS[7:2]) ? SCS_RESP_OK : SCS_RESP_SLVERR;
      end else if (BVALID_OUT && BREADY_IN) begin
        BVALID_OUT <= 1'b0;
      end
    end
  end
  logic wr_cmd, wr_cfg, wr_irq, wr_mask, wr_et, wr_it;
  assign wr_cmd = wr_fire && awaddr_reg == SCS_CMD_OFS && wstrb_reg[0];
  assign wr_cfg = wr_fire && awaddr_reg == SCS_CFG_OFS && wstrb_reg[0];
  assign wr_irq = wr_fire && awaddr_reg == SCS_IRQ_OFS && wstrb_reg[0];
  assign wr_mask = wr_fire && awaddr_reg == SCS_MASK_OFS && wstrb_reg[0];
  assign wr_et = wr_fire && awaddr_reg == SCS_ETIME_OFS;
  assign wr_it = wr_fire && awaddr_reg == SCS_ITIME_OFS;
  // ==========================================
  // configuration: bit0 calibratable country, bit1 total1 in log text 1
  logic [2:0] cfg_reg;
  logic [15:0] etime_reg, itime_reg;
  logic [SCS_IRQ_W-1:0] mask_reg;
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      cfg_reg <= SCS_CFG_RST;
      etime_reg <= SCS_TIME_RST;
      itime_reg <= SCS_TIME_RST;
      mask_reg <= '0;
    end else begin
      if (wr_cfg) cfg_reg <= wdata_reg[2:0];
      if (wr_mask) mask_reg <= wdata_reg[SCS_IRQ_W-1:0];
      if (wr_et && wstrb_reg[0]) etime_reg[7:0] <= wdata_reg[7:0];
      if (wr_et && wstrb_reg[1]) etime_reg[15:8] <= wdata_reg[15:8];
      if (wr_it && wstrb_reg[0]) itime_reg[7:0] <= wdata_reg[7:0];
      if (wr_it && wstrb_reg[1]) itime_reg[15:8] <= wdata_reg[15:8];
    end
  end
  // ==========================================
  // command decode against the operating state
  scs_state_t state_reg, resume_reg;
  logic [7:0] code;
  logic in_cycle, stopped, allowed;
  assign code = wdata_reg[7:0];
  assign in_cycle = state_reg == SCS_WEIGH || state_reg == SCS_EMPTY;
  assign stopped = state_reg == SCS_STOP;
  always_comb begin
    case (code)
      SCS_C_CONT, SCS_C_PULSE, SCS_C_ABORT: allowed = stopped;
      SCS_C_STOP: allowed = in_cycle;
      SCS_C_ENDC: allowed = stopped || in_cycle;
      SCS_C_CHK: allowed = !PROC_IN.service;
      SCS_C_RESID: allowed = stopped || state_reg == SCS_WEIGH;
      SCS_C_INHON, SCS_C_INHOFF: allowed = 1'b1;
      SCS_C_EMPON, SCS_C_EMPOFF, SCS_C_CLRT1, SCS_C_CLRT2: allowed = !in_cycle && !stopped;
      SCS_C_LOGT1: allowed = !in_cycle && !stopped && cfg_reg[1];
      default: allowed = 1'b0;
    endcase
    if (code == SCS_C_CLRT1 && cfg_reg[0]) allowed = 1'b0;
  end
  logic acc, rej;
  assign acc = wr_cmd && allowed;
  assign rej = wr_cmd && !allowed;
  // ==========================================
  // cycle state machine
  logic chk_arm_reg, end_cont_reg, cont_reg;
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      state_reg <= SCS_IDLE;
      resume_reg <= SCS_WEIGH;
      chk_arm_reg <= 1'b0;
      end_cont_reg <= 1'b0;
      cont_reg <= 1'b0;
      PULSE_MODE_OUT <= 1'b0;
    end else begin
      if (acc && code == SCS_C_CHK) chk_arm_reg <= 1'b1;
      if (acc && code == SCS_C_ENDC) end_cont_reg <= 1'b1;
      case (state_reg)
        SCS_IDLE: begin
          end_cont_reg <= 1'b0;
          if (PROC_IN.start_cont) begin
            state_reg <= SCS_WEIGH;
            cont_reg <= 1'b1;
            PULSE_MODE_OUT <= 1'b0;
          end
        end
        SCS_WEIGH: begin
          if (acc && code == SCS_C_STOP) begin
            resume_reg <= SCS_WEIGH;
            state_reg <= SCS_STOP;
          end else if (acc && code == SCS_C_RESID) begin
            state_reg <= SCS_EMPTY;
            cont_reg <= 1'b0;
          end else if (chk_arm_reg && PROC_IN.check_step) begin
            resume_reg <= SCS_WEIGH;
            chk_arm_reg <= 1'b0;
            state_reg <= SCS_STOP;
          end else if (PROC_IN.weigh_done) begin
            state_reg <= SCS_EMPTY;
          end
        end
        SCS_EMPTY: begin
          if (acc && code == SCS_C_STOP) begin
            resume_reg <= SCS_EMPTY;
            state_reg <= SCS_STOP;
          end else if (PROC_IN.empty_range) begin
            // end of cycle: next cycle only while continuous and not ended
            state_reg <= (cont_reg && !end_cont_reg) ? SCS_WEIGH : SCS_IDLE;
            PULSE_MODE_OUT <= 1'b0;
            if (end_cont_reg) cont_reg <= 1'b0;
          end
        end
        SCS_STOP: begin
          if (acc && code == SCS_C_CONT) begin
            state_reg <= resume_reg;
          end else if (acc && code == SCS_C_PULSE) begin
            state_reg <= SCS_WEIGH;
            PULSE_MODE_OUT <= 1'b1;
          end else if (acc && code == SCS_C_ABORT) begin
            state_reg <= SCS_IDLE;
            cont_reg <= 1'b0;
            PULSE_MODE_OUT <= 1'b0;
          end else if (acc && code == SCS_C_RESID) begin
            state_reg <= SCS_EMPTY;
            cont_reg <= 1'b0;
          end
        end
        default: state_reg <= SCS_IDLE;
      endcase
    end
  end
  // ==========================================
  // action pulses toward the weighing core
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      ACT_OUT <= '0;
    end else begin
      ACT_OUT.abort <= acc && code == SCS_C_ABORT;
      ACT_OUT.record_wt <= acc && code == SCS_C_RESID;
      ACT_OUT.log_t1 <= acc && code == SCS_C_LOGT1;
      ACT_OUT.clr_t1 <= acc && (code == SCS_C_LOGT1 || code == SCS_C_CLRT1);
      ACT_OUT.clr_t2 <= acc && code == SCS_C_CLRT2;
    end
  end
  // ==========================================
  // emptying output: manual or sequence-driven
  logic man_empty_reg;
  logic [15:0] etimer_reg;
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      man_empty_reg <= 1'b0;
      etimer_reg <= 16'h0000;
    end else if (acc && code == SCS_C_EMPOFF) begin
      man_empty_reg <= 1'b0;
    end else if (acc && code == SCS_C_EMPON) begin
      man_empty_reg <= 1'b1;
      etimer_reg <= etime_reg;
    end else if (man_empty_reg) begin
      if (etime_reg == 16'h0000) begin
        if (PROC_IN.empty_range) man_empty_reg <= 1'b0;
      end else if (etimer_reg <= 16'h0001) begin
        man_empty_reg <= 1'b0;
      end else begin
        etimer_reg <= etimer_reg - 16'h0001;
      end
    end
  end
  logic empty_next;
  assign empty_next = man_empty_reg || state_reg == SCS_EMPTY;
  // ==========================================
  // inhibition time (cycles) and error 17 gating
  logic [15:0] itimer_reg;
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      itimer_reg <= 16'h0000;
    end else if (acc && code == SCS_C_INHOFF) begin
      itimer_reg <= 16'h0000;
    end else if (acc && code == SCS_C_INHON) begin
      itimer_reg <= itime_reg;
    end else if (itimer_reg != 16'h0000) begin
      itimer_reg <= itimer_reg - 16'h0001;
    end
  end
  logic err17_next;
  assign err17_next = PROC_IN.meas_err && itimer_reg == 16'h0000;
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      EMPTY_OUT <= 1'b0;
      INHIBIT_OUT <= 1'b0;
      ERR17_OUT <= 1'b0;
    end else begin
      EMPTY_OUT <= empty_next;
      INHIBIT_OUT <= itimer_reg != 16'h0000;
      ERR17_OUT <= err17_next;
    end
  end
  // ==========================================
  // sticky interrupt status, write one to clear, set wins
  logic [SCS_IRQ_W-1:0] irq_reg, ev;
  assign ev = {err17_next, rej, acc};
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      irq_reg <= '0;
      IRQ_OUT <= 1'b0;
    end else begin
      irq_reg <= (irq_reg & ~(wr_irq ? wdata_reg[SCS_IRQ_W-1:0] : '0)) | ev;
      IRQ_OUT <= |(irq_reg & mask_reg);
    end
  end
  // ==========================================
  // axi4-lite read path
  logic [31:0] rd_mux;
  logic [7:0] last_code_reg;
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) last_code_reg <= 8'h00;
    else if (wr_cmd) last_code_reg <= code;
  end
  always_comb begin
    case (ARADDR_IN)
      SCS_CMD_OFS: rd_mux = {24'h000000, last_code_reg};
      SCS_STAT_OFS: rd_mux = {20'h00000, chk_arm_reg, end_cont_reg, cont_reg,
                              PULSE_MODE_OUT, state_reg, man_empty_reg, INHIBIT_OUT,
                              1'b0, 1'b0};
      SCS_CFG_OFS: rd_mux = {29'h0, cfg_reg};
      SCS_IRQ_OFS: rd_mux = {29'h0, irq_reg};
      SCS_MASK_OFS: rd_mux = {29'h0, mask_reg};
      SCS_ETIME_OFS: rd_mux = {16'h0000, etime_reg};
      SCS_ITIME_OFS: rd_mux = {16'h0000, itime_reg};
      SCS_ID_OFS: rd_mux = SCS_ID_VAL;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      RVALID_OUT <= 1'b0;
      RDATA_OUT <= 32'h0000_0000;
      RRESP_OUT <= SCS_RESP_OK;
      ARREADY_OUT <= 1'b0;
    end else begin
      ARREADY_OUT <= !(ARVALID_IN && ARREADY_OUT) && !(RVALID_OUT && !RREADY_IN);
      if (ARVALID_IN && ARREADY_OUT) begin
        RVALID_OUT <= 1'b1;
        RDATA_OUT <= rd_mux;
        RRESP_OUT <= (ARADDR_IN[1:0] == 2'b00 && ARADDR_IN <= SCS_ID_OFS) ?
                     SCS_RESP_OK : SCS_RESP_SLVERR;
      end else if (RVALID_OUT && RREADY_IN) begin
        RVALID_OUT <= 1'b0;
      end
    end
  end
  // ==========================================
  // checks
  property p_stop;
    @(posedge CLK_IN) disable iff (SRST_IN)
      (acc && code == SCS_C_STOP) |=> state_reg == SCS_STOP;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");
  property p_rej_hold;
    @(posedge CLK_IN) disable iff (SRST_IN)
      (rej && !PROC_IN.start_cont && !PROC_IN.weigh_done && !PROC_IN.empty_range
       && !PROC_IN.check_step) |=> $stable(state_reg);
  endproperty
  a_rej_hold: assert property (p_rej_hold) else $error("rejected command moved fsm");
  property p_rej_irq;
    @(posedge CLK_IN) disable iff (SRST_IN) rej |=> irq_reg[SCS_IRQ_REJ];
  endproperty
  a_rej_irq: assert property (p_rej_irq) else $error("rejection not reported");
  property p_cont;
    @(posedge CLK_IN) disable iff (SRST_IN)
      (acc && code == SCS_C_CONT) |=> state_reg == $past(resume_reg);
  endproperty
  a_cont: assert property (p_cont) else $error("continue wrong target");
  property p_pulse;
    @(posedge CLK_IN) disable iff (SRST_IN)
      (acc && code == SCS_C_PULSE) |=> PULSE_MODE_OUT && state_reg == SCS_WEIGH;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse continue failed");
  property p_abort;
    @(posedge CLK_IN) disable iff (SRST_IN)
      (acc && code == SCS_C_ABORT) |=> state_reg == SCS_IDLE && ACT_OUT.abort;
  endproperty
  a_abort: assert property (p_abort) else $error("abort failed");
  property p_empoff;
    @(posedge CLK_IN) disable iff (SRST_IN)
      (acc && code == SCS_C_EMPOFF) |=> ##1 !EMPTY_OUT;
  endproperty
  a_empoff: assert property (p_empoff) else $error("empty off ignored");
  property p_empon;
    @(posedge CLK_IN) disable iff (SRST_IN)
      (acc && code == SCS_C_EMPON) |=> ##1 EMPTY_OUT;
  endproperty
  a_empon: assert property (p_empon) else $error("empty on ignored");
  property p_inh;
    @(posedge CLK_IN) disable iff (SRST_IN)
      INHIBIT_OUT |-> !ERR17_OUT;
  endproperty
  a_inh: assert property (p_inh) else $error("error 17 during inhibition");
  property p_inhoff;
    @(posedge CLK_IN) disable iff (SRST_IN)
      (acc && code == SCS_C_INHOFF) |=> ##1 !INHIBIT_OUT;
  endproperty
  a_inhoff: assert property (p_inhoff) else $error("inhibition not ended");
  property p_resid;
    @(posedge CLK_IN) disable iff (SRST_IN)
      (acc && code == SCS_C_RESID) |=> ACT_OUT.record_wt && state_reg == SCS_EMPTY;
  endproperty
  a_resid: assert property (p_resid) else $error("residual weighing failed");
  property p_chk_stop;
    @(posedge CLK_IN) disable iff (SRST_IN)
      (state_reg == SCS_WEIGH && chk_arm_reg && PROC_IN.check_step && !wr_cmd)
      |=> state_reg == SCS_STOP && !chk_arm_reg;
  endproperty
  a_chk_stop: assert property (p_chk_stop) else $error("check stop not taken");
  c_chk_stop: cover property (@(posedge CLK_IN) disable iff (SRST_IN)
    chk_arm_reg && PROC_IN.check_step && state_reg == SCS_WEIGH);
  c_stop_cont: cover property (@(posedge CLK_IN) disable iff (SRST_IN)
    (acc && code == SCS_C_STOP) ##[1:50] (acc && code == SCS_C_CONT));
  c_rej: cover property (@(posedge CLK_IN) disable iff (SRST_IN) rej);
  c_inh: cover property (@(posedge CLK_IN) disable iff (SRST_IN) INHIBIT_OUT && PROC_IN.meas_err);
endmodule

/* File: common/scs_pkg.sv */
// package: constants, states and carrier types of the scale command sequencer
// assumes one 100 MHz clock and an axi4-lite master that writes command codes
package scs_pkg;
  // ==========================================
  // register map (byte addresses)
  localparam logic [7:0] SCS_CMD_OFS = 8'h00;
  localparam logic [7:0] SCS_STAT_OFS = 8'h04;
  localparam logic [7:0] SCS_CFG_OFS = 8'h08;
  localparam logic [7:0] SCS_IRQ_OFS = 8'h0c;
  localparam logic [7:0] SCS_MASK_OFS = 8'h10;
  localparam logic [7:0] SCS_ETIME_OFS = 8'h14;
  localparam logic [7:0] SCS_ITIME_OFS = 8'h18;
  localparam logic [7:0] SCS_ID_OFS = 8'h1c;
  // arbitrary identification value
  localparam logic [31:0] SCS_ID_VAL = 32'h5c5c_0001;
  localparam logic [1:0] SCS_RESP_OK = 2'h0;
  localparam logic [1:0] SCS_RESP_SLVERR = 2'h2;
  // ==========================================
  // command codes
  localparam logic [7:0] SCS_C_CONT = 8'h67;
  localparam logic [7:0] SCS_C_PULSE = 8'h68;
  localparam logic [7:0] SCS_C_STOP = 8'h69;
  localparam logic [7:0] SCS_C_ENDC = 8'h6a;
  localparam logic [7:0] SCS_C_CHK = 8'h6b;
  localparam logic [7:0] SCS_C_ABORT = 8'h6c;
  localparam logic [7:0] SCS_C_EMPON = 8'h6d;
  localparam logic [7:0] SCS_C_RESID = 8'h6e;
  localparam logic [7:0] SCS_C_INHON = 8'h6f;
  localparam logic [7:0] SCS_C_INHOFF = 8'h70;
  localparam logic [7:0] SCS_C_LOGT1 = 8'h71;
  localparam logic [7:0] SCS_C_CLRT1 = 8'h72;
  localparam logic [7:0] SCS_C_CLRT2 = 8'h73;
  localparam logic [7:0] SCS_C_EMPOFF = 8'h76;
  localparam int SCS_MEAS_ERR = 17;
  // ==========================================
  // status / irq bit positions
  localparam int SCS_IRQ_DONE = 0;
  localparam int SCS_IRQ_REJ = 1;
  localparam int SCS_IRQ_ERR17 = 2;
  localparam int SCS_IRQ_W = 3;
  localparam logic [2:0] SCS_CFG_RST = 3'h0;
  localparam logic [15:0] SCS_TIME_RST = 16'h0000;
  // ==========================================
  typedef enum logic [3:0] {
    SCS_IDLE = 4'b0001,
    SCS_WEIGH = 4'b0010,
    SCS_EMPTY = 4'b0100,
    SCS_STOP = 4'b1000
  } scs_state_t;
  // process-side inputs from the weighing core
  typedef struct packed {
    logic service;
    logic check_step;
    logic weigh_done;
    logic empty_range;
    logic meas_err;
    logic start_cont;
  } scs_proc_t;
  // one-cycle actions toward the weighing core
  typedef struct packed {
    logic abort;
    logic record_wt;
    logic log_t1;
    logic clr_t1;
    logic clr_t2;
  } scs_act_t;
endpackage

/* File: verification/scs_host_model.sv */
// host controller model: axi4-lite master issuing register accesses
// assumes the slave answers in its own time; the bench watchdog ends a hang
`timescale 1ns/1ps
module scs_host_model (
  input wire logic clk_in,
  output logic [7:0] awaddr_out,
  output logic awvalid_out,
  input wire logic awready_in,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  output logic wvalid_out,
  input wire logic wready_in,
  input wire logic [1:0] bresp_in,
  input wire logic bvalid_in,
  output logic bready_out,
  output logic [7:0] araddr_out,
  output logic arvalid_out,
  input wire logic arready_in,
  input wire logic [31:0] rdata_in,
  input wire logic [1:0] rresp_in,
  input wire logic rvalid_in,
  output logic rready_out
);
  // ==========================================
  // idle levels; ready is looked at on the low phase, which equals its value at the next edge
  initial begin
    {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out, bready_out} = '0;
    {araddr_out, arvalid_out, rready_out} = '0;
  end
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    @(posedge clk_in);
    awaddr_out <= a;
    wdata_out <= d;
    wstrb_out <= 4'hf;
    awvalid_out <= 1'b1;
    wvalid_out <= 1'b1;
    bready_out <= 1'b1;
    while (!b_ok) begin
      @(negedge clk_in);
      if (awvalid_out && awready_in) aw_ok = 1'b1;
      if (wvalid_out && wready_in) w_ok = 1'b1;
      b_ok = aw_ok && w_ok && !awvalid_out && !wvalid_out && bvalid_in;
      r = bresp_in;
      @(posedge clk_in);
      if (aw_ok) awvalid_out <= 1'b0;
      if (w_ok) wvalid_out <= 1'b0;
    end
    bready_out <= 1'b0;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok;
    logic r_ok;
    ar_ok = 1'b0;
    r_ok = 1'b0;
    @(posedge clk_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    rready_out <= 1'b1;
    while (!r_ok) begin
      @(negedge clk_in);
      if (arvalid_out && arready_in) ar_ok = 1'b1;
      r_ok = ar_ok && !arvalid_out && rvalid_in;
      d = rdata_in;
      r = rresp_in;
      @(posedge clk_in);
      if (ar_ok) arvalid_out <= 1'b0;
    end
    rready_out <= 1'b0;
  endtask
endmodule

/* File: verification/tb_top.sv */
// testbench: drives commands over axi4-lite and process events, judges outputs
// assumes the sequencer and the host model; status read back shows the fsm state
`timescale 1ns/1ps
module tb_top import scs_pkg::*; ;
  logic CLK_IN;
  logic SRST_IN;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  scs_proc_t proc;
  scs_act_t act, act_seen;
  logic act_clr, pulse_mode, empty_o, inhibit_o, err17_o, irq_o;
  logic [31:0] rd;
  int fail_count = 0;
  int n_tests = 0;
  scs_sequencer dut (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .AWADDR_IN(awaddr),
    .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb),
    .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
    .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
    .PROC_IN(proc), .ACT_OUT(act), .PULSE_MODE_OUT(pulse_mode), .EMPTY_OUT(empty_o),
    .INHIBIT_OUT(inhibit_o), .ERR17_OUT(err17_o), .IRQ_OUT(irq_o));
  scs_host_model host (.clk_in(CLK_IN), .awaddr_out(awaddr), .awvalid_out(awvalid),
    .awready_in(awready), .wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid),
    .wready_in(wready), .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready),
    .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata),
    .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));
  // ==========================================
  // clock, reset, pulse catcher (action pulses last one cycle only)
  initial begin
    CLK_IN = 1'b0;
    forever #5 CLK_IN = ~CLK_IN;
  end
  always @(posedge CLK_IN) begin
    if (act_clr) act_seen <= '0;
    else act_seen <= act_seen | act;
  end
  task automatic test_done();
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (exp !== got) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ==========================================
  // helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.write_reg(a, d, resp);
    repeat (3) @(posedge CLK_IN);
  endtask
  task automatic cmd(input logic [7:0] c);
    act_clr <= 1'b1;
    @(posedge CLK_IN);
    act_clr <= 1'b0;
    wr(SCS_CMD_OFS, {24'h0, c});
  endtask
  task automatic rd_reg(input logic [7:0] a);
    host.read_reg(a, rd, resp);
  endtask
  task automatic chk_state(input scs_state_t s);
    rd_reg(SCS_STAT_OFS);
    chk("state", {28'h0, s}, {28'h0, rd[7:4]});
  endtask
  task automatic ev_start();
    proc.start_cont <= 1'b1;
    @(posedge CLK_IN);
    proc.start_cont <= 1'b0;
    repeat (3) @(posedge CLK_IN);
  endtask
  task automatic chk_rej(input logic exp);
    rd_reg(SCS_IRQ_OFS);
    chk("rejected", {31'h0, exp}, {31'h0, rd[SCS_IRQ_REJ]});
    wr(SCS_IRQ_OFS, 32'h0000_000f);
  endtask
  // ==========================================
  // scenarios
  task automatic t_basic();
    chk_state(SCS_IDLE);
    rd_reg(SCS_ID_OFS);
    chk("id", SCS_ID_VAL, rd);
    rd_reg(8'h40);
    chk("unmapped resp", {30'h0, SCS_RESP_SLVERR}, {30'h0, resp});
    cmd(SCS_C_CONT);
    chk_state(SCS_IDLE);
    chk_rej(1'b1);
    host.write_reg(8'h40, 32'h0000_0000, resp);
    chk("unmapped wr resp", {30'h0, SCS_RESP_SLVERR}, {30'h0, resp});
    wr(SCS_MASK_OFS, 32'h0000_0002);
    chk("wr resp", {30'h0, SCS_RESP_OK}, {30'h0, resp});
    cmd(SCS_C_STOP);
    chk("irq level", 32'h1, {31'h0, irq_o});
    wr(SCS_IRQ_OFS, 32'h0000_0002);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    $display("test basic done");
  endtask
  task automatic t_stop();
    ev_start();
    chk_state(SCS_WEIGH);
    cmd(SCS_C_STOP);
    chk_state(SCS_STOP);
    cmd(SCS_C_CONT);
    chk_state(SCS_WEIGH);
    cmd(SCS_C_STOP);
    cmd(SCS_C_PULSE);
    chk_state(SCS_WEIGH);
    chk("pulse mode", 32'h1, {31'h0, pulse_mode});
    cmd(SCS_C_STOP);
    cmd(SCS_C_EMPON);
    chk_rej(1'b1);
    cmd(SCS_C_ABORT);
    chk_state(SCS_IDLE);
    chk("abort", 32'h1, {31'h0, act_seen.abort});
    chk("no empty", 32'h0, {31'h0, empty_o});
    chk_rej(1'b0);
    $display("test stop done");
  endtask
  task automatic t_empty();
    wr(SCS_ETIME_OFS, 32'h0);
    cmd(SCS_C_EMPON);
    chk("empty on", 32'h1, {31'h0, empty_o});
    cmd(SCS_C_EMPOFF);
    chk("empty off", 32'h0, {31'h0, empty_o});
    cmd(SCS_C_EMPON);
    repeat (20) @(posedge CLK_IN);
    chk("empty held", 32'h1, {31'h0, empty_o});
    proc.empty_range <= 1'b1;
    repeat (5) @(posedge CLK_IN);
    chk("empty range", 32'h0, {31'h0, empty_o});
    proc.empty_range <= 1'b0;
    wr(SCS_ETIME_OFS, 32'h0000_0004);
    cmd(SCS_C_EMPON);
    repeat (5) @(posedge CLK_IN);
    chk("empty timed", 32'h0, {31'h0, empty_o});
    $display("test empty done");
  endtask
  task automatic t_inhibit();
    wr(SCS_ITIME_OFS, 32'h0000_00c8);
    proc.meas_err <= 1'b1;
    repeat (3) @(posedge CLK_IN);
    chk("err17", 32'h1, {31'h0, err17_o});
    cmd(SCS_C_INHON);
    chk("inhibit", 32'h1, {31'h0, inhibit_o});
    chk("err17 hidden", 32'h0, {31'h0, err17_o});
    cmd(SCS_C_INHOFF);
    chk("inhibit end", 32'h0, {31'h0, inhibit_o});
    chk("err17 back", 32'h1, {31'h0, err17_o});
    cmd(SCS_C_INHON);
    repeat (190) @(posedge CLK_IN);
    chk("inhibit runs", 32'h1, {31'h0, inhibit_o});
    repeat (20) @(posedge CLK_IN);
    chk("inhibit expired", 32'h0, {31'h0, inhibit_o});
    proc.meas_err <= 1'b0;
    $display("test inhibit done");
  endtask
  task automatic t_totals();
    wr(SCS_CFG_OFS, 32'h0);
    cmd(SCS_C_LOGT1);
    chk("no log", 32'h0, {31'h0, act_seen.log_t1});
    wr(SCS_CFG_OFS, 32'h2);
    cmd(SCS_C_LOGT1);
    chk("log t1", 32'h3, {30'h0, act_seen.log_t1, act_seen.clr_t1});
    wr(SCS_CFG_OFS, 32'h1);
    cmd(SCS_C_CLRT1);
    chk("no clr t1", 32'h0, {31'h0, act_seen.clr_t1});
    wr(SCS_CFG_OFS, 32'h0);
    cmd(SCS_C_CLRT1);
    chk("clr t1", 32'h1, {31'h0, act_seen.clr_t1});
    cmd(SCS_C_CLRT2);
    chk("clr t2", 32'h1, {31'h0, act_seen.clr_t2});
    ev_start();
    cmd(SCS_C_CLRT2);
    chk("t2 in cycle", 32'h0, {31'h0, act_seen.clr_t2});
    chk_rej(1'b1);
    $display("test totals done");
  endtask
  task automatic t_cycle();
    cmd(SCS_C_RESID);
    chk_state(SCS_EMPTY);
    chk("record", 32'h1, {31'h0, act_seen.record_wt});
    proc.empty_range <= 1'b1;
    repeat (10) @(posedge CLK_IN);
    chk_state(SCS_IDLE);
    proc.empty_range <= 1'b0;
    ev_start();
    cmd(SCS_C_ENDC);
    rd_reg(SCS_STAT_OFS);
    chk("end cont", 32'h1, {31'h0, rd[10]});
    proc.weigh_done <= 1'b1;
    @(posedge CLK_IN);
    proc.weigh_done <= 1'b0;
    proc.empty_range <= 1'b1;
    repeat (10) @(posedge CLK_IN);
    chk_state(SCS_IDLE);
    proc.empty_range <= 1'b0;
    ev_start();
    cmd(SCS_C_CHK);
    rd_reg(SCS_STAT_OFS);
    chk("check armed", 32'h1, {31'h0, rd[11]});
    proc.check_step <= 1'b1;
    @(posedge CLK_IN);
    proc.check_step <= 1'b0;
    chk_state(SCS_STOP);
    cmd(SCS_C_ABORT);
    proc.service <= 1'b1;
    cmd(SCS_C_CHK);
    chk_rej(1'b1);
    proc.service <= 1'b0;
    $display("test cycle done");
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    SRST_IN = 1'b1;
    proc = '0;
    act_clr = 1'b1;
    repeat (5) @(posedge CLK_IN);
    SRST_IN <= 1'b0;
    act_clr <= 1'b0;
    @(posedge CLK_IN);
    t_basic();
    t_stop();
    t_empty();
    t_inhibit();
    t_totals();
    t_cycle();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge CLK_IN);
    fail_count++;
    test_done();
  end
endmodule
